// file: pkg/usart_cfg_pkg.sv
package usart_cfg_pkg;

    // Register byte addresses
    localparam logic [31:0] ADDR_LINE_CFG = 32'h40024004;
    localparam logic [31:0] ADDR_IRQ_SET = 32'h40024008;
    localparam logic [31:0] ADDR_IRQ_CLEAR = 32'h4002400C;
    localparam logic [31:0] ADDR_IRQ_VIEW = 32'h40024010;

    // Reset values and implemented bits
    localparam logic [31:0] LINE_CFG_RESET = 32'h00000000;
    localparam logic [31:0] LINE_CFG_VALID = 32'hF7FFFFFF;
    localparam logic [31:0] IRQ_MASK_RESET = 32'h00000000;
    localparam logic [31:0] IRQ_MASK_VALID = 32'h010F3FFF;

    // Shared mask/status position: repeat limit or SPI underrun
    localparam int IRQ_BIT_REPEAT = 10;

    // Operating mode codes
    localparam logic [3:0] MODE_ISO_T0 = 4'h4;
    localparam logic [3:0] MODE_ISO_T1 = 4'h6;
    localparam logic [3:0] MODE_SPI_MASTER = 4'hE;
    localparam logic [3:0] MODE_SPI_SLAVE = 4'hF;
    localparam logic [1:0] CLK_SRC_EXTERNAL = 2'h3;

    // Character sizes
    localparam int CHAR_W = 9;
    localparam logic [3:0] CHAR_LEN_BASE = 4'h5;
    localparam logic [3:0] CHAR_LEN_NINE = 4'h9;
    localparam int THR_SYNC_BIT = 15;

    typedef enum logic [1:0] {
        CH_NORMAL = 2'b00,
        CH_ECHO = 2'b01,
        CH_LOCAL = 2'b10,
        CH_REMOTE = 2'b11
    } chan_mode_type;

    typedef enum logic [0:0] {
        TX_IDLE = 1'b0,
        TX_WAIT = 1'b1
    } tx_state_type;

    // Line configuration, most significant field first
    typedef struct packed {
        logic delimiter_select;
        logic manchester_start_polarity;
        logic manchester_enable;
        logic rx_filter_enable;
        logic reserved27;
        logic [2:0] repeat_limit;
        logic data_invert;
        logic var_sync;
        logic successive_nack_disable;
        logic nack_inhibit;
        logic oversample_8;
        logic serial_clock_output_enable;
        logic nine_bit_char_enable;
        logic order_or_idle;
        chan_mode_type channel_test_select;
        logic [1:0] stop_bits;
        logic [2:0] parity_type;
        logic sync_or_phase;
        logic [1:0] char_length_field;
        logic [1:0] clock_source_select;
        logic [3:0] op_mode;
    } line_cfg_type;

    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } reg_req_type;

endpackage : usart_cfg_pkg

// file: core/rx_majority_filter.sv
`timescale 1ns/1ps
module rx_majority_filter (
    input wire logic clk_in, // Peripheral clock
    input wire logic sys_rst_in, // Synchronous reset
    input wire logic sample_en_in, // One-sixteenth bit sample pulse
    input wire logic line_in, // Synchronised receive line
    output logic filtered_out // Two-of-three vote
);
    logic [2:0] samples_r;

    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            samples_r <= 3'h7;
            filtered_out <= 1'b1;
        end
        else if (sample_en_in)
        begin
            samples_r <= {samples_r[1:0], line_in};
            filtered_out <= (samples_r[1] & samples_r[0]) | (samples_r[1] & line_in)
                | (samples_r[0] & line_in);
        end
    end
endmodule : rx_majority_filter

// file: core/char_reorder.sv
`timescale 1ns/1ps
module char_reorder (
    input wire logic [8:0] data_in, // Character, first-shifted bit at index 0
    input wire logic [3:0] bits_in, // Character length 5 to 9
    input wire logic msb_first_in, // Reverse within the length
    input wire logic invert_in, // Invert data polarity
    output logic [8:0] data_out // Reordered character, upper bits zero
);
    always_comb
    begin
        int j;
        j = 0;
        data_out = 9'h000;
        for (int i = 0; i < 9; i++)
        begin
            j = msb_first_in ? (int'(bits_in) - 1 - i) : i;
            if (i < int'(bits_in) && j >= 0)
            begin
                data_out[i] = data_in[j] ^ invert_in;
            end
        end
    end
endmodule : char_reorder

// file: core/usart_mode_irq.sv
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
// Operation
// - Channel field picks normal, echo, local, remote
// - Bit order outside SPI: 0 LSB first, 1 MSB first
// - SPI clock idles at polarity bit level
// - Nine-bit flag overrides character length field
// - Drive clock pin only if enabled, internal source
// - NACK inhibit suppresses non-acknowledge
// - SPI master start waits for receive-ready clear when the NACK inhibit bit is set
// - Parity error sends immediate NACK normally
// - Count repeats to limit, then stop, flag
// - Data invert flips transmit and receive data
// - Sync field from polarity or each write
// - Optional two-of-three receive line filter
// - Manchester enable switches coder on or off
// - Start bit polarity selects transition direction
// - Delimiter select: sync pattern or one bit
// - Enable-set write ones set mask bits
// - Enable-clear write ones clear mask bits
// - Mask view reads enabled sources as ones
// - Mask bit layout fixed by source
// - Bit ten shared: repeats or SPI underrun
module usart_mode_irq (
    input wire logic clk_in, // 40 MHz peripheral clock
    input wire logic sys_rst_in, // Synchronous reset, active high
    input wire usart_cfg_pkg::reg_req_type reg_req_in, // Register request
    output logic [31:0] reg_rdata_out, // Read data, cycle after read strobe
    input wire logic [31:0] status_flags_in, // Status flags in mask layout
    output logic irq_out, // Interrupt request level
    input wire logic rxd_pin_in, // Receive pin, asynchronous
    output logic txd_pin_out, // Transmit pin
    input wire logic sck_pin_in, // Serial clock pin, asynchronous
    output logic sck_pin_out, // Serial clock pin drive value
    output logic sck_pin_oe_out, // Serial clock pin output enable
    output logic sck_edge_out, // Pulse on each sampled clock pin edge
    input wire logic sample_tick_in, // One-sixteenth bit enable pulse
    input wire logic core_tx_bit_in, // Serial bit from the transmitter
    output logic core_rx_bit_out, // Serial bit to the receiver
    input wire logic core_sck_in, // Internal shift clock, idle low
    input wire logic core_sck_active_in, // Internal shift clock is running
    input wire logic thr_write_in, // Transmit holding write pulse
    input wire logic [15:0] thr_data_in, // Transmit holding write data
    input wire logic tx_ready_flag_in, // Transmit-ready status
    input wire logic rx_ready_flag_in, // Receive-ready status
    output logic tx_start_out, // Start one character, pulse
    output logic [8:0] tx_char_out, // Character in shift order
    output logic tx_sync_out, // Sync field: 1 command, 0 data
    input wire logic rx_char_valid_in, // Received character pulse
    input wire logic [8:0] rx_char_in, // Received character, shift order
    input wire logic rx_parity_err_in, // Parity error with this character
    output logic [8:0] rx_data_out, // Character for receive holding
    output logic nack_send_out, // Send a non-acknowledge, pulse
    input wire logic repeat_reset_in, // Clear the repeat limit flag
    output logic repeat_limit_flag_out, // Repeat limit reached, sticky
    output logic [3:0] char_bits_out, // Character length in bits
    output logic msb_first_out, // Shift most significant bit first
    output logic manchester_enable_out, // Manchester coder enabled
    output logic start_falling_out, // Start bit is a high-to-low edge
    output logic delimiter_select_out // One-bit delimiter instead of sync
);
    usart_cfg_pkg::line_cfg_type cfg_r;
    usart_cfg_pkg::tx_state_type tx_state_r;
    logic [31:0] mask_r;
    logic [31:0] rdata_r;
    logic [31:0] set_bits;
    logic [31:0] clr_bits;
    logic [31:0] eff_status;
    logic wr_cfg;
    logic wr_set;
    logic wr_clr;
    logic irq_any;
    logic irq_r;
    logic rxd_meta_r;
    logic rxd_sync_r;
    logic sck_meta_r;
    logic sck_sync_r;
    logic sck_prev_r;
    logic rx_filtered;
    logic rx_line;
    logic txd_r;
    logic core_rx_r;
    logic sck_out_r;
    logic sck_oe_r;
    logic spi_mode;
    logic spi_master;
    logic iso_mode;
    logic iso_t0;
    logic nack_off_w;
    logic start_ok;
    logic start_r;
    logic [8:0] tx_char_r;
    logic [8:0] tx_ordered;
    logic sync_r;
    logic [8:0] rx_data_r;
    logic [8:0] rx_ordered;
    logic [2:0] repeat_cnt_r;
    logic nack_r;
    logic repeat_r;
    logic limit_hit;
    logic [3:0] char_bits;

    assign wr_cfg = reg_req_in.wr && (reg_req_in.addr == usart_cfg_pkg::ADDR_LINE_CFG);
    assign wr_set = reg_req_in.wr && (reg_req_in.addr == usart_cfg_pkg::ADDR_IRQ_SET);
    assign wr_clr = reg_req_in.wr && (reg_req_in.addr == usart_cfg_pkg::ADDR_IRQ_CLEAR);
    assign set_bits = reg_req_in.wdata & usart_cfg_pkg::IRQ_MASK_VALID;
    assign clr_bits = reg_req_in.wdata & usart_cfg_pkg::IRQ_MASK_VALID;

    assign spi_master = cfg_r.op_mode == usart_cfg_pkg::MODE_SPI_MASTER;
    assign spi_mode = spi_master || (cfg_r.op_mode == usart_cfg_pkg::MODE_SPI_SLAVE);
    assign iso_t0 = cfg_r.op_mode == usart_cfg_pkg::MODE_ISO_T0;
    assign iso_mode = iso_t0 || (cfg_r.op_mode == usart_cfg_pkg::MODE_ISO_T1);
    assign nack_off_w = cfg_r.nack_inhibit;

    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
            cfg_r <= usart_cfg_pkg::line_cfg_type'(usart_cfg_pkg::LINE_CFG_RESET);
        else if (wr_cfg)
            cfg_r <= usart_cfg_pkg::line_cfg_type'(reg_req_in.wdata
                & usart_cfg_pkg::LINE_CFG_VALID);
    end

    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
            mask_r <= usart_cfg_pkg::IRQ_MASK_RESET;
        else if (wr_set)
            mask_r <= mask_r | set_bits;
        else if (wr_clr)
            mask_r <= mask_r & ~clr_bits;
    end

    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
            rdata_r <= 32'h00000000;
        else if (reg_req_in.rd)
        begin
            case (reg_req_in.addr)
                usart_cfg_pkg::ADDR_LINE_CFG: rdata_r <= 32'(cfg_r);
                usart_cfg_pkg::ADDR_IRQ_VIEW: rdata_r <= mask_r;
                default: rdata_r <= 32'h00000000;
            endcase
        end
        else
            rdata_r <= 32'h00000000;
    end
    assign reg_rdata_out = rdata_r;

    // Bit ten reports repeats in card modes, underrun otherwise
    always_comb
    begin
        eff_status = status_flags_in & usart_cfg_pkg::IRQ_MASK_VALID;
        if (iso_mode)
            eff_status[usart_cfg_pkg::IRQ_BIT_REPEAT] = repeat_r;
    end
    assign irq_any = |(eff_status & mask_r);

    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
            irq_r <= 1'b0;
        else
            irq_r <= irq_any;
    end
    assign irq_out = irq_r;

    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            rxd_meta_r <= 1'b1;
            rxd_sync_r <= 1'b1;
            sck_meta_r <= 1'b0;
            sck_sync_r <= 1'b0;
            sck_prev_r <= 1'b0;
        end
        else
        begin
            rxd_meta_r <= rxd_pin_in;
            rxd_sync_r <= rxd_meta_r;
            sck_meta_r <= sck_pin_in;
            sck_sync_r <= sck_meta_r;
            sck_prev_r <= sck_sync_r;
        end
    end
    assign sck_edge_out = sck_sync_r ^ sck_prev_r;

    rx_majority_filter u_filter (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .sample_en_in(sample_tick_in),
        .line_in(rxd_sync_r),
        .filtered_out(rx_filtered)
    );
    assign rx_line = cfg_r.rx_filter_enable ? rx_filtered : rxd_sync_r;

    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            txd_r <= 1'b1;
            core_rx_r <= 1'b1;
        end
        else
        begin
            case (cfg_r.channel_test_select)
                usart_cfg_pkg::CH_NORMAL:
                begin
                    txd_r <= core_tx_bit_in;
                    core_rx_r <= rx_line;
                end
                usart_cfg_pkg::CH_ECHO:
                begin
                    txd_r <= rx_line;
                    core_rx_r <= rx_line;
                end
                usart_cfg_pkg::CH_LOCAL:
                begin
                    txd_r <= 1'b1;
                    core_rx_r <= core_tx_bit_in;
                end
                usart_cfg_pkg::CH_REMOTE:
                begin
                    txd_r <= rxd_sync_r;
                    core_rx_r <= 1'b1;
                end
                default:
                begin
                    txd_r <= 1'b1;
                    core_rx_r <= 1'b1;
                end
            endcase
        end
    end
    assign txd_pin_out = txd_r;
    assign core_rx_bit_out = core_rx_r;

    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            sck_out_r <= 1'b0;
            sck_oe_r <= 1'b0;
        end
        else
        begin
            if (spi_mode)
                sck_out_r <= core_sck_active_in ? (core_sck_in ^ cfg_r.order_or_idle)
                    : cfg_r.order_or_idle;
            else
                sck_out_r <= core_sck_in;
            sck_oe_r <= cfg_r.serial_clock_output_enable
                && (cfg_r.clock_source_select != usart_cfg_pkg::CLK_SRC_EXTERNAL);
        end
    end
    assign sck_pin_out = sck_out_r;
    assign sck_pin_oe_out = sck_oe_r;

    // Shared bit is the clock polarity in SPI, which always shifts MSB first
    assign msb_first_out = spi_mode ? 1'b1 : cfg_r.order_or_idle;
    assign char_bits = cfg_r.nine_bit_char_enable ? usart_cfg_pkg::CHAR_LEN_NINE
        : 4'(usart_cfg_pkg::CHAR_LEN_BASE + {2'b00, cfg_r.char_length_field});
    assign char_bits_out = char_bits;
    assign manchester_enable_out = cfg_r.manchester_enable;
    assign start_falling_out = cfg_r.manchester_start_polarity;
    assign delimiter_select_out = cfg_r.delimiter_select;

    char_reorder u_tx_order (
        .data_in(thr_data_in[8:0]),
        .bits_in(char_bits),
        .msb_first_in(msb_first_out),
        .invert_in(cfg_r.data_invert),
        .data_out(tx_ordered)
    );

    char_reorder u_rx_order (
        .data_in(rx_char_in),
        .bits_in(char_bits),
        .msb_first_in(msb_first_out),
        .invert_in(cfg_r.data_invert),
        .data_out(rx_ordered)
    );

    assign start_ok = !(spi_master && cfg_r.nack_inhibit && rx_ready_flag_in);

    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            tx_state_r <= usart_cfg_pkg::TX_IDLE;
            start_r <= 1'b0;
            tx_char_r <= 9'h000;
        end
        else
        begin
            start_r <= 1'b0;
            case (tx_state_r)
                usart_cfg_pkg::TX_IDLE:
                begin
                    if (thr_write_in && tx_ready_flag_in)
                    begin
                        tx_char_r <= tx_ordered;
                        if (start_ok)
                            start_r <= 1'b1;
                        else
                            tx_state_r <= usart_cfg_pkg::TX_WAIT;
                    end
                end
                usart_cfg_pkg::TX_WAIT:
                begin
                    if (start_ok)
                    begin
                        start_r <= 1'b1;
                        tx_state_r <= usart_cfg_pkg::TX_IDLE;
                    end
                end
                default: tx_state_r <= usart_cfg_pkg::TX_IDLE;
            endcase
        end
    end
    assign tx_start_out = start_r;
    assign tx_char_out = tx_char_r;

    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
            sync_r <= 1'b0;
        else if (!cfg_r.var_sync)
            sync_r <= cfg_r.manchester_start_polarity;
        else if (thr_write_in)
            sync_r <= thr_data_in[usart_cfg_pkg::THR_SYNC_BIT];
    end
    assign tx_sync_out = sync_r;

    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
            rx_data_r <= 9'h000;
        else if (rx_char_valid_in)
            rx_data_r <= rx_ordered;
    end
    assign rx_data_out = rx_data_r;

    assign limit_hit = rx_char_valid_in && rx_parity_err_in && !cfg_r.nack_inhibit
        && cfg_r.successive_nack_disable && iso_t0 && (repeat_cnt_r >= cfg_r.repeat_limit);

    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            nack_r <= 1'b0;
            repeat_cnt_r <= 3'h0;
        end
        else
        begin
            nack_r <= 1'b0;
            if (rx_char_valid_in)
            begin
                if (!rx_parity_err_in)
                    repeat_cnt_r <= 3'h0;
                else if (!cfg_r.nack_inhibit)
                begin
                    if (cfg_r.successive_nack_disable && iso_t0)
                    begin
                        if (repeat_cnt_r < cfg_r.repeat_limit)
                        begin
                            nack_r <= 1'b1;
                            repeat_cnt_r <= repeat_cnt_r + 3'h1;
                        end
                    end
                    else
                        nack_r <= 1'b1;
                end
            end
        end
    end
    assign nack_send_out = nack_r;

    // Reaching the limit wins over a clear in the same cycle
    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
            repeat_r <= 1'b0;
        else if (limit_hit)
            repeat_r <= 1'b1;
        else if (repeat_reset_in)
            repeat_r <= 1'b0;
    end
    assign repeat_limit_flag_out = repeat_r;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);

    property p_mask_set;
        wr_set |=> ((mask_r & $past(set_bits)) == $past(set_bits));
    endproperty
    a_mask_set: assert property (p_mask_set) else $error("mask bit not set");

    property p_mask_clr;
        wr_clr |=> ((mask_r & $past(clr_bits)) == 32'h00000000);
    endproperty
    a_mask_clr: assert property (p_mask_clr) else $error("mask bit not cleared");

    property p_mask_keep;
        !(wr_set || wr_clr) |=> $stable(mask_r);
    endproperty
    a_mask_keep: assert property (p_mask_keep) else $error("mask changed unasked");

    property p_view_read;
        (reg_req_in.rd && reg_req_in.addr == usart_cfg_pkg::ADDR_IRQ_VIEW)
            |=> (reg_rdata_out == $past(mask_r));
    endproperty
    a_view_read: assert property (p_view_read) else $error("mask view wrong");

    property p_mask_reset;
        @(posedge clk_in) disable iff (1'b0) sys_rst_in |=> (mask_r == 32'h00000000);
    endproperty
    a_mask_reset: assert property (p_mask_reset) else $error("mask not reset");

    property p_irq;
        1'b1 |=> (irq_out == $past(irq_any));
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt level wrong");

    property p_nack_inhibit;
        nack_send_out |-> !$past(nack_off_w);
    endproperty
    a_nack_inhibit: assert property (p_nack_inhibit) else $error("nack while inhibited");

    property p_nack_parity;
        (rx_char_valid_in && rx_parity_err_in && !nack_off_w && !cfg_r.successive_nack_disable)
            |=> nack_send_out;
    endproperty
    a_nack_parity: assert property (p_nack_parity) else $error("nack missing");

    property p_limit;
        limit_hit |=> (repeat_limit_flag_out && !nack_send_out);
    endproperty
    a_limit: assert property (p_limit) else $error("repeat limit wrong");

    property p_local_idle;
        (cfg_r.channel_test_select == usart_cfg_pkg::CH_LOCAL) ##1
            (cfg_r.channel_test_select == usart_cfg_pkg::CH_LOCAL) |-> txd_pin_out;
    endproperty
    a_local_idle: assert property (p_local_idle) else $error("txd not idle in loopback");

    property p_tx_start;
        tx_start_out |-> $past(start_ok);
    endproperty
    a_tx_start: assert property (p_tx_start) else $error("start while receive ready");

    c_echo: cover property (cfg_r.channel_test_select == usart_cfg_pkg::CH_ECHO ##1 txd_pin_out);
    c_limit: cover property (limit_hit ##1 repeat_limit_flag_out);
    c_tx_wait: cover property (tx_state_r == usart_cfg_pkg::TX_WAIT ##[1:20] tx_start_out);
    c_irq: cover property (!irq_out ##1 irq_out);
endmodule : usart_mode_irq

// file: test/serial_peer.sv
`timescale 1ns/1ps
module serial_peer (
    output logic rxd_out, // Data toward the device, idles high
    output logic sck_out // Bit clock, still between frames
);
    initial
    begin
        rxd_out = 1'b1;
        sck_out = 1'b0;
    end
    // Start bit, eight data bits, stop bit on a 200 ns bit clock
    task automatic send(input logic [7:0] d);
        logic [9:0] f;
        f = {1'b1, d, 1'b0};
        #13;
        for (int i = 0; i < 10; i++)
        begin
            rxd_out = f[i];
            #100 sck_out = 1'b1;
            #100 sck_out = 1'b0;
        end
        rxd_out = 1'b1;
    endtask : send
endmodule : serial_peer

// file: test/tb_usart_mode_irq.sv
`timescale 1ns/1ps
module tb_usart_mode_irq;
    localparam logic [31:0] A_CFG = usart_cfg_pkg::ADDR_LINE_CFG;
    localparam logic [31:0] A_SET = usart_cfg_pkg::ADDR_IRQ_SET;
    localparam logic [31:0] A_CLR = usart_cfg_pkg::ADDR_IRQ_CLEAR;
    localparam logic [31:0] A_VIEW = usart_cfg_pkg::ADDR_IRQ_VIEW;
    logic clk_in = 0, sys_rst_in = 1, tick = 0, ctx = 1, csck = 0, thw = 0, txr = 1, rxr = 0;
    logic rv = 0, rpe = 0, rrst = 0, irq, txd, sck_o, oe, crx, tst, tsy, nack, rflag;
    logic mfirst, menc, sfall, dsel, p_rxd, p_sck, sck, sck_edge, spi, cact = 0;
    logic [31:0] status = 0, v, r, msk, rdata;
    logic [15:0] thd = 0;
    logic [8:0] tch, rc = 0, rdo, e9;
    logic [3:0] cbits;
    usart_cfg_pkg::reg_req_type req = '0;
    int err_total = 0, compares = 0, n, k, edges = 0, ne;
    assign sck = oe ? sck_o : p_sck;
    always #12.5 clk_in = ~clk_in;
    always @(posedge clk_in) tick <= ~tick;
    always @(posedge clk_in)
        if (sck_edge === 1'b1) edges <= edges + 1;
    serial_peer peer (.rxd_out(p_rxd), .sck_out(p_sck));
    usart_mode_irq dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .reg_req_in(req),
        .reg_rdata_out(rdata), .status_flags_in(status), .irq_out(irq), .rxd_pin_in(p_rxd),
        .txd_pin_out(txd), .sck_pin_in(sck), .sck_pin_out(sck_o), .sck_pin_oe_out(oe),
        .sck_edge_out(sck_edge), .sample_tick_in(tick), .core_tx_bit_in(ctx),
        .core_rx_bit_out(crx), .core_sck_in(csck), .core_sck_active_in(cact),
        .thr_write_in(thw), .thr_data_in(thd),
        .tx_ready_flag_in(txr), .rx_ready_flag_in(rxr), .tx_start_out(tst), .tx_char_out(tch),
        .tx_sync_out(tsy), .rx_char_valid_in(rv), .rx_char_in(rc), .rx_parity_err_in(rpe),
        .rx_data_out(rdo), .nack_send_out(nack), .repeat_reset_in(rrst),
        .repeat_limit_flag_out(rflag), .char_bits_out(cbits), .msb_first_out(mfirst),
        .manchester_enable_out(menc), .start_falling_out(sfall), .delimiter_select_out(dsel));
    task automatic chk(input string nm, input logic [31:0] s, e);
        compares++;
        if (s !== e)
        begin
            err_total++;
            $display("unexpected %s: expected %h, seen %h", nm, e, s);
        end
    endtask : chk
    task automatic wr(input logic [31:0] a, d);
        @(posedge clk_in) req <= '{a, d, 1'b1, 1'b0};
        @(posedge clk_in) req.wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [31:0] a, output logic [31:0] d);
        @(posedge clk_in) req <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge clk_in) req.rd <= 1'b0;
        #1 d = rdata;
    endtask : rd
    task automatic tx(input logic [15:0] d);
        @(posedge clk_in) thw <= 1'b1;
        thd <= d;
        @(posedge clk_in) thw <= 1'b0;
        #1;
    endtask : tx
    task automatic rx(input logic [8:0] d);
        @(posedge clk_in) rv <= 1'b1;
        rc <= d;
        rpe <= 1'b1;
        @(posedge clk_in) rv <= 1'b0;
        #1;
    endtask : rx
    // Eight-bit character in shift order
    function automatic logic [8:0] ord8(input logic [7:0] d, input logic m, x);
        ord8 = 9'h0;
        for (int i = 0; i < 8; i++) ord8[i] = (m ? d[7 - i] : d[i]) ^ x;
    endfunction : ord8
    task automatic test_done;
        $display("compares %0d, err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : test_done
    initial
    begin
        #1000000;
        err_total++;
        test_done;
    end
    initial
    begin
        void'($urandom(39));
        repeat (12) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        status <= '1;
        rd(A_VIEW, r);
        chk("mask", r, 0);
        chk("irq", irq, 0);
        rd(32'h40024014, r);
        chk("unmapped", r, 0);
        msk = 0;
        for (n = 0; n < 12; n++)
        begin
            v = n == 0 ? '1 : $urandom;
            wr(n[0] ? A_CLR : A_SET, v);
            msk = n[0] ? msk & ~v : msk | (v & usart_cfg_pkg::IRQ_MASK_VALID);
            rd(A_VIEW, r);
            chk("mask", r, msk);
            @(posedge clk_in) status <= $urandom & $urandom & $urandom;
            @(posedge clk_in) #1;
            chk("irq", irq, (status & msk) != 0);
        end
        for (n = 0; n < 8; n++)
        begin
            v = $urandom;
            if (n < 2) v[3:0] = 4'hE + n[3:0];
            @(posedge clk_in) csck <= $urandom;
            cact <= $urandom;
            spi = v[3:1] == 3'b111;
            wr(A_CFG, v);
            rd(A_CFG, r);
            chk("config", r, v & usart_cfg_pkg::LINE_CFG_VALID);
            chk("bits", cbits, v[17] ? 9 : 5 + v[7:6]);
            chk("order", mfirst, spi || v[16]);
            chk("clk oe", oe, v[18] && v[5:4] != 2'h3);
            chk("clk idle", sck_o, !spi ? csck : cact ? csck ^ v[16] : v[16]);
            chk("coder", {menc, sfall, dsel}, {v[29], v[30], v[31]});
            if (!v[22]) chk("sync", tsy, v[30]);
        end
        for (n = 0; n < 5; n++)
        begin
            // Fifth frame: echo through the receive filter
            wr(A_CFG, n == 4 ? 32'h10004000 : 32'(n) << 14);
            fork
                peer.send(8'($urandom));
            join_none
            for (k = 0; k < 10; k++)
            begin
                @(posedge p_sck);
                if (k == 0) ne = edges;
                @(posedge clk_in) ctx <= $urandom;
                repeat (2) @(posedge clk_in);
                #1;
                chk("txd", txd, n == 2 ? 1 : n == 0 ? ctx : p_rxd);
                chk("core rx", crx, n == 3 ? 1 : n == 2 ? ctx : p_rxd);
            end
            repeat (8) @(posedge clk_in);
            chk("sck edges", edges - ne, 20);
        end
        for (n = 0; n < 4; n++)
        begin
            wr(A_CFG, {8'h0, n[1], 6'h0, n[0], 16'h00C0});
            e9 = 9'($urandom);
            tx({8'h0, e9[7:0]});
            chk("start", tst, 1);
            chk("tx char", tch, ord8(e9[7:0], n[0], n[1]));
        end
        wr(A_CFG, 32'h005000CE);
        rxr <= 1'b1;
        tx(16'h8055);
        chk("start", tst, 0);
        repeat (3) @(posedge clk_in);
        rxr <= 1'b0;
        k = 0;
        while (tst !== 1'b1 && k < 4)
        begin
            @(posedge clk_in) #1;
            k++;
        end
        chk("start", tst, 1);
        chk("sync", tsy, 1);
        status <= 0;
        wr(A_SET, 32'h00000400);
        wr(A_CFG, 32'h02A000C4);
        for (n = 0; n < 3; n++)
        begin
            e9 = 9'($urandom);
            rx({1'b0, e9[7:0]});
            chk("nack", nack, n < 2);
            chk("rx data", rdo, ord8(e9[7:0], 1'b0, 1'b1));
        end
        chk("repeat flag", rflag, 1);
        @(posedge clk_in) #1;
        chk("irq", irq, 1);
        @(posedge clk_in) rrst <= 1'b1;
        @(posedge clk_in) rrst <= 1'b0;
        @(posedge clk_in) #1;
        chk("repeat flag", rflag, 0);
        for (n = 0; n < 2; n++)
        begin
            wr(A_CFG, {11'h0, n[0], 20'h000C0});
            rx(9'h0A5);
            chk("nack", nack, !n[0]);
        end
        test_done;
    end
endmodule : tb_usart_mode_irq
